// ===== shared_regfile_pkg.sv
// Overview of operation
// - 256 byte file shared by program and master
// - File is 16 groups of 16 registers
// - Group pointer selects working group for short addresses
// - Window pointer places 16 master registers anywhere
// - Both sides read and write window registers
// - Four extra control/status registers, both sides access
// - Master cannot reach locations outside shared space
`default_nettype none
package shared_regfile_pkg;
  localparam int AddrW     = 8;
  localparam int DataW     = 8;
  localparam int GroupW    = 4;
  localparam int IdxW      = 4;
  localparam int CtlIdxW   = 2;
  localparam int CtlCount  = 4;
  localparam logic [AddrW-1:0] WinBaseRst = 8'h00;
  localparam logic [GroupW-1:0] GroupRst  = 4'h0;
  localparam logic [DataW-1:0] DataRst    = 8'h00;

  // Internal program access
  typedef struct packed {
    logic             rd;
    logic             wr;
    logic             shortForm;
    logic [AddrW-1:0] addr;
    logic [DataW-1:0] wdata;
  } progReq_t;

  // Master access: window index or control register
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic               ctlSel;
    logic [IdxW-1:0]    idx;
    logic [DataW-1:0]   wdata;
  } mastReq_t;
endpackage
`default_nettype wire

// ===== ctl_byte.sv
`default_nettype none
module ctl_byte
  import shared_regfile_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             progWe,
  input  wire logic [DataW-1:0] progData,
  input  wire logic             mastWe,
  input  wire logic [DataW-1:0] mastData,
  output logic      [DataW-1:0] value
);
  logic [DataW-1:0] value_d;

  // Master write wins a same-cycle collision
  always_comb
  begin
    value_d = value;
    if (progWe)
      value_d = progData;
    if (mastWe)
      value_d = mastData;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      value <= DataRst;
    else
      value <= value_d;
  end
endmodule
`default_nettype wire

// ===== shared_register_file_window.sv
`default_nettype none
module shared_register_file_window
  import shared_regfile_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire progReq_t         progReq,
  input  wire logic             progCtlSel,
  input  wire logic             groupWe,
  input  wire logic [GroupW-1:0] groupIn,
  input  wire logic             winWe,
  input  wire logic [AddrW-1:0] winIn,
  input  wire logic             shareWe,
  input  wire logic [AddrW-1:0] shareAddr,
  input  wire logic             shareVal,
  input  wire mastReq_t         mastReq,
  output logic      [DataW-1:0] progRdata_q,
  output logic      [DataW-1:0] mastRdata_q,
  output logic                  mastDenied_q,
  output logic      [GroupW-1:0] groupPtr_q,
  output logic      [AddrW-1:0] winBase_q
);
  localparam int Depth = 1 << AddrW;

  logic [DataW-1:0] mem [Depth];
  logic [Depth-1:0] shared_q;
  logic [Depth-1:0] shared_d;
  logic [GroupW-1:0] groupPtr_d;
  logic [AddrW-1:0] winBase_d;
  logic [DataW-1:0] progRdata_d;
  logic [DataW-1:0] mastRdata_d;
  logic             mastDenied_d;
  logic [AddrW-1:0] progAddr;
  logic [AddrW-1:0] mastAddr;
  logic             mastOk;
  logic             mastMemWe;
  logic             progMemWe;
  logic [DataW-1:0] ctlVal [CtlCount];

  // Address formation
  always_comb
  begin
    progAddr = progReq.shortForm
             ? {groupPtr_q, progReq.addr[IdxW-1:0]}
             : progReq.addr;
    mastAddr = winBase_q + AddrW'(mastReq.idx);
    mastOk   = shared_q[mastAddr];
    mastMemWe = mastReq.wr && !mastReq.ctlSel && mastOk;
    progMemWe = progReq.wr && !progCtlSel;
  end

  // Control registers for both sides
  for (genvar i = 0; i < CtlCount; i++)
  begin : g_ctl
    ctl_byte u_ctl (
      .clk      (clk),
      .arst_n   (arst_n),
      .progWe   (progReq.wr && progCtlSel && progReq.addr[CtlIdxW-1:0] == CtlIdxW'(i)),
      .progData (progReq.wdata),
      .mastWe   (mastReq.wr && mastReq.ctlSel && mastReq.idx[CtlIdxW-1:0] == CtlIdxW'(i)),
      .mastData (mastReq.wdata),
      .value    (ctlVal[i])
    );
  end

  // Next-state of pointers, share map, read data
  always_comb
  begin
    groupPtr_d   = groupWe ? groupIn : groupPtr_q;
    winBase_d    = winWe ? winIn : winBase_q;
    shared_d     = shared_q;
    if (shareWe)
      shared_d[shareAddr] = shareVal;
    progRdata_d  = progRdata_q;
    mastRdata_d  = mastRdata_q;
    mastDenied_d = 1'b0;
    if (progReq.rd)
      progRdata_d = progCtlSel ? ctlVal[progReq.addr[CtlIdxW-1:0]] : mem[progAddr];
    if (mastReq.rd || mastReq.wr)
    begin
      if (mastReq.ctlSel)
      begin
        if (mastReq.rd)
          mastRdata_d = ctlVal[mastReq.idx[CtlIdxW-1:0]];
      end
      else if (mastOk)
      begin
        if (mastReq.rd)
          mastRdata_d = mem[mastAddr];
      end
      else
      begin
        mastDenied_d = 1'b1;
        if (mastReq.rd)
          mastRdata_d = DataRst;
      end
    end
  end

  // Pointer, share map and read-data registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      groupPtr_q   <= GroupRst;
      winBase_q    <= WinBaseRst;
      shared_q     <= '0;
      progRdata_q  <= DataRst;
      mastRdata_q  <= DataRst;
      mastDenied_q <= 1'b0;
    end
    else
    begin
      groupPtr_q   <= groupPtr_d;
      winBase_q    <= winBase_d;
      shared_q     <= shared_d;
      progRdata_q  <= progRdata_d;
      mastRdata_q  <= mastRdata_d;
      mastDenied_q <= mastDenied_d;
    end
  end

  // File storage; master write wins a collision
  always_ff @(posedge clk)
  begin
    if (progMemWe)
      mem[progAddr] <= progReq.wdata;
    if (mastMemWe)
      mem[mastAddr] <= mastReq.wdata;
  end

  // Refused master write raises the deny pulse
  chk_denied_nowrite: assert property (@(posedge clk) disable iff (!arst_n)
    (mastReq.wr && !mastReq.ctlSel && !mastOk)
      |=> mastDenied_q)
    else $error("protected master write not flagged");

  // Window read returns the byte at base plus index
  chk_window_read: assert property (@(posedge clk) disable iff (!arst_n)
    (mastReq.rd && !mastReq.ctlSel && mastOk && !progMemWe && !mastMemWe)
      |=> mastRdata_q == $past(mem[mastAddr]))
    else $error("window read mismatch");

  // Group pointer moves only on a load
  chk_group_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !groupWe
      |=> $stable(groupPtr_q))
    else $error("group pointer moved");

  // Window base takes the loaded value
  chk_base_load: assert property (@(posedge clk) disable iff (!arst_n)
    winWe
      |=> winBase_q == $past(winIn))
    else $error("window base not loaded");

  // Legal master access is never refused
  chk_ok_nodeny: assert property (@(posedge clk) disable iff (!arst_n)
    ((mastReq.rd || mastReq.wr) && (mastReq.ctlSel || mastOk))
      |=> !mastDenied_q)
    else $error("legal access denied");

  // Master control write reads back on the next cycle
  chk_ctl_write: assert property (@(posedge clk) disable iff (!arst_n)
    (mastReq.wr && mastReq.ctlSel) ##1 (mastReq.rd && mastReq.ctlSel
      && mastReq.idx == $past(mastReq.idx) && !progReq.wr)
      |=> mastRdata_q == $past(mastReq.wdata, 2))
    else $error("control readback wrong");

  // Short form takes its group bits from the pointer
  chk_short_addr: assert property (@(posedge clk) disable iff (!arst_n)
    progReq.shortForm
      |-> progAddr[AddrW-1:IdxW] == groupPtr_q)
    else $error("short address group wrong");

  // No access, no deny pulse
  chk_deny_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    !(mastReq.rd || mastReq.wr)
      |=> !mastDenied_q)
    else $error("spurious deny");

  // Refused master read returns zero with a deny pulse
  chk_denied_rdzero: assert property (@(posedge clk) disable iff (!arst_n)
    (mastReq.rd && !mastReq.ctlSel && !mastOk)
      |=> (mastRdata_q == DataRst) && mastDenied_q)
    else $error("refused read not zero");

  // Refused master write leaves the protected byte alone
  chk_prot_nowrite: assert property (@(posedge clk) disable iff (!arst_n)
    (mastReq.wr && !mastReq.ctlSel && !mastOk && !(progMemWe && progAddr == mastAddr))
      |=> mem[$past(mastAddr)] == $past(mem[mastAddr]))
    else $error("protected byte changed");

  // Accepted master write lands in the window byte
  chk_win_write: assert property (@(posedge clk) disable iff (!arst_n)
    (mastReq.wr && !mastReq.ctlSel && mastOk)
      |=> mem[$past(mastAddr)] == $past(mastReq.wdata))
    else $error("window write lost");

  // Program write lands unless the master wins the same byte
  chk_prog_write: assert property (@(posedge clk) disable iff (!arst_n)
    (progMemWe && !(mastMemWe && mastAddr == progAddr))
      |=> mem[$past(progAddr)] == $past(progReq.wdata))
    else $error("program write lost");

  // Program file read returns the addressed byte
  chk_prog_read: assert property (@(posedge clk) disable iff (!arst_n)
    (progReq.rd && !progCtlSel && !progMemWe && !mastMemWe)
      |=> progRdata_q == $past(mem[progAddr]))
    else $error("program read mismatch");

  // Group pointer takes the loaded value
  chk_group_load: assert property (@(posedge clk) disable iff (!arst_n)
    groupWe
      |=> groupPtr_q == $past(groupIn))
    else $error("group pointer not loaded");

  // Window base moves only on a load
  chk_base_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !winWe
      |=> $stable(winBase_q))
    else $error("window base moved");

  // Share map bit follows the program's marking
  chk_share_set: assert property (@(posedge clk) disable iff (!arst_n)
    shareWe
      |=> shared_q[$past(shareAddr)] == $past(shareVal))
    else $error("share bit not set");

  // Program read data holds between reads
  chk_prog_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !progReq.rd
      |=> $stable(progRdata_q))
    else $error("program read data moved");

  // Master read data holds between reads
  chk_mast_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !mastReq.rd
      |=> $stable(mastRdata_q))
    else $error("master read data moved");

  // Program control read returns the control byte
  chk_ctl_progread: assert property (@(posedge clk) disable iff (!arst_n)
    (progReq.rd && progCtlSel)
      |=> progRdata_q == $past(ctlVal[progReq.addr[CtlIdxW-1:0]]))
    else $error("program control read wrong");

  // Master control read returns the control byte
  chk_ctl_mastread: assert property (@(posedge clk) disable iff (!arst_n)
    (mastReq.rd && mastReq.ctlSel)
      |=> mastRdata_q == $past(ctlVal[mastReq.idx[CtlIdxW-1:0]]))
    else $error("master control read wrong");
endmodule
`default_nettype wire

// ===== master_cpu_model.sv
`default_nettype none
module master_cpu_model
  import shared_regfile_pkg::*;
(
  input  wire logic clk,
  output var  mastReq_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // One-cycle access; released lines show the inverse, never stale data
  task automatic access(input logic wr, input logic ctl, input logic [IdxW-1:0] idx,
                        input logic [DataW-1:0] d);
    @(posedge clk);
    req <= '{rd: !wr, wr: wr, ctlSel: ctl, idx: idx, wdata: d};
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b0, ctlSel: !ctl, idx: ~idx, wdata: ~d};
  endtask

  // Control write and read-back in consecutive cycles
  task automatic ctl_write_read(input logic [IdxW-1:0] idx, input logic [DataW-1:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, ctlSel: 1'b1, idx: idx, wdata: d};
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, ctlSel: 1'b1, idx: idx, wdata: ~d};
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b0, ctlSel: 1'b0, idx: ~idx, wdata: d};
  endtask
endmodule
`default_nettype wire

// ===== shared_register_file_window_tb.sv
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module shared_register_file_window_tb
  import shared_regfile_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, arst_n, progCtlSel, groupWe, winWe, shareWe, shareVal, denied;
  logic [GroupW-1:0] groupIn, groupPtr;
  logic [AddrW-1:0]  winIn, shareAddr, progRd, mastRd, winBase;
  progReq_t          progReq;
  mastReq_t          mastReq;
  int                n_errors, checks_done, cycles;

  shared_register_file_window DUT (.clk(clk), .arst_n(arst_n), .progReq(progReq),
    .progCtlSel(progCtlSel), .groupWe(groupWe), .groupIn(groupIn), .winWe(winWe),
    .winIn(winIn), .shareWe(shareWe), .shareAddr(shareAddr), .shareVal(shareVal),
    .mastReq(mastReq), .progRdata_q(progRd), .mastRdata_q(mastRd),
    .mastDenied_q(denied), .groupPtr_q(groupPtr), .winBase_q(winBase));
  master_cpu_model PM (.clk(clk), .req(mastReq));

  always #10 clk = ~clk;

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Program access, one cycle, settled result after the answer edge
  task automatic prog(input logic wr, ctl, sh, input logic [7:0] a, d);
    @(posedge clk);
    progReq <= '{rd: !wr, wr: wr, shortForm: sh, addr: a, wdata: d};
    progCtlSel <= ctl;
    @(posedge clk);
    progReq <= '0;
    progCtlSel <= 1'b0;
    #1;
  endtask

  // Pointer and share-map loads
  task automatic setup(input logic [3:0] g, input logic [7:0] b, s);
    @(posedge clk);
    {groupWe, groupIn, winWe, winIn, shareWe, shareAddr, shareVal} <= {1'b1, g, 1'b1, b,
      1'b1, s, 1'b1};
    @(posedge clk);
    {groupWe, winWe, shareWe} <= 3'h0;
    #1;
  endtask

  task automatic mast(input logic wr, ctl, input logic [3:0] i, input logic [7:0] d);
    PM.access(wr, ctl, i, d);
    #1;
  endtask

  // Window mapping and two-way exchange
  task automatic t_window();
    setup(4'h0, 8'h30, 8'h35);
    `CHK(winBase, 8'h30)
    prog(1, 0, 0, 8'h35, 8'ha5);
    mast(0, 0, 4'h5, 8'h00);
    `CHK(mastRd, 8'ha5)
    `CHK(denied, 1'b0)
    mast(1, 0, 4'h5, 8'h5a);
    prog(0, 0, 0, 8'h35, 8'h00);
    `CHK(progRd, 8'h5a)
  endtask

  // Protected byte: write ignored, read zero, refusal pulse
  task automatic t_protect();
    prog(1, 0, 0, 8'h36, 8'h77);
    mast(1, 0, 4'h6, 8'h11);
    `CHK(denied, 1'b1)
    mast(0, 0, 4'h6, 8'h00);
    `CHK({denied, mastRd}, 9'h100)
    prog(0, 0, 0, 8'h36, 8'h00);
    `CHK(progRd, 8'h77)
  endtask

  // Short form through the group pointer, window wrapping at the top
  task automatic t_group();
    setup(4'hf, 8'hf8, 8'h07);
    `CHK(groupPtr, 4'hf)
    prog(1, 0, 1, 8'h03, 8'hc3);
    prog(0, 0, 0, 8'hf3, 8'h00);
    `CHK(progRd, 8'hc3)
    prog(1, 0, 0, 8'h07, 8'h9e);
    mast(0, 0, 4'hf, 8'h00);
    `CHK(mastRd, 8'h9e)
  endtask

  // Four control bytes, written by the master, read by the program
  task automatic t_ctl();
    for (int i = 0; i < CtlCount; i++) mast(1, 1, 4'(i), 8'h40 + 8'(i));
    for (int i = 0; i < CtlCount; i++)
    begin
      prog(0, 1, 0, 8'(i), 8'h00);
      `CHK(progRd, 8'h40 + 8'(i))
    end
    PM.ctl_write_read(4'h2, 8'h6c);
    #1;
    `CHK(mastRd, 8'h6c)
    prog(0, 1, 0, 8'h02, 8'h00);
    `CHK(progRd, 8'h6c)
  endtask

  initial
  begin
    {clk, arst_n, progCtlSel, groupWe, winWe, shareWe, shareVal} = '0;
    {groupIn, winIn, shareAddr, progReq} = '0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    `CHK({groupPtr, winBase, denied}, 13'h0000)
    t_window();
    t_protect();
    t_group();
    t_ctl();
    tally_and_finish();
  end
endmodule
`default_nettype wire
